// *** hw/lccr_map.vh ***
`ifndef LCCR_MAP_VH
`define LCCR_MAP_VH
// register byte addresses in the configuration space
`define LCCR_ADDR_OUT_CFG 8'h00
`define LCCR_ADDR_BIAS_CFG 8'h01
// reset values
`define LCCR_OUT_CFG_RST 8'h00
`define LCCR_BIAS_CFG_RST 8'h02
// output_and_monitor_config fields
`define LCCR_B_SOFT_RST 7
`define LCCR_B_GPO_LVL 6
`define LCCR_B_DIODE_FLT 5
`define LCCR_B_OUT_EN 4
`define LCCR_B_MOD_REF 3
`define LCCR_F_AUX_HI 2
`define LCCR_F_AUX_LO 0
// bits of output_and_monitor_config kept in non-volatile storage
`define LCCR_OUT_CFG_NV_MASK 8'h5f
// bias_loop_config fields
`define LCCR_B_LOOP_INV 7
`define LCCR_B_GAIN 6
`define LCCR_B_BIAS_REF 5
`define LCCR_F_RFB_HI 4
`define LCCR_F_RFB_LO 2
`define LCCR_B_DRIVE_DIR 1
`define LCCR_B_SHUTDOWN_OUTPUT_POL 0
`define LCCR_BIAS_CFG_NV_MASK 8'hff
// timing
`define LCCR_CLK_PERIOD_NS 20
`define LCCR_SOFT_RST_NS 1000
`define LCCR_SOFT_RST_CYC ((`LCCR_SOFT_RST_NS + `LCCR_CLK_PERIOD_NS - 1) / `LCCR_CLK_PERIOD_NS)
// conversion slot whose result feeds the aux voltage result
`define LCCR_AUX_SLOT 3'h0
`define LCCR_ADC_SLOTS 7
`endif

// *** hw/lccr_adc_seq.v ***
`timescale 1ns/1ps
`include "lccr_map.vh"
module lccr_adc_seq #(
  parameter CH_W = 3,
  parameter NUM_CH = `LCCR_ADC_SLOTS,
  parameter DATA_W = 10
) (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // control from the register bank
  input wire seq_abort,
  input wire seq_restart,
  // converter handshake
  output reg adc_start,
  output reg adc_abort,
  output reg [CH_W-1:0] adc_ch,
  input wire adc_done,
  input wire [DATA_W-1:0] adc_data,
  // results
  output reg res_valid,
  output reg [CH_W-1:0] res_ch,
  output reg [DATA_W-1:0] res_data
);
  localparam S_IDLE = 2'd0;
  localparam S_START = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam [CH_W-1:0] LAST_CH = NUM_CH - 1;

  reg [1:0] state_r;

  // sequencer; abort beats everything so a late done is dropped
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_START;
      adc_start <= 1'b0;
      adc_abort <= 1'b0;
      adc_ch <= {CH_W{1'b0}};
      res_valid <= 1'b0;
      res_ch <= {CH_W{1'b0}};
      res_data <= {DATA_W{1'b0}};
    end else begin
      adc_start <= 1'b0;
      adc_abort <= 1'b0;
      res_valid <= 1'b0;
      if (seq_abort) begin
        state_r <= S_IDLE;
        adc_abort <= 1'b1;
      end else if (seq_restart) begin
        state_r <= S_START;
        adc_ch <= {CH_W{1'b0}};
      end else begin
        case (state_r)
          S_IDLE: state_r <= S_IDLE;
          S_START: begin
            adc_start <= 1'b1;
            state_r <= S_WAIT;
          end
          S_WAIT: begin
            if (adc_done) begin
              res_valid <= 1'b1;
              res_ch <= adc_ch;
              res_data <= adc_data;
              adc_ch <= (adc_ch == LAST_CH) ? {CH_W{1'b0}} : adc_ch + 1'b1;
              state_r <= S_START;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// *** hw/lccr_config_regs.v ***
// What this block does
// - writing soft reset one restarts whole device
// - level bit drives open-drain pin while general_output_mode_select is low, reset_mode_drive_low while it is high
// - diode fault flag reports detected fault
// - output enable drives or floats three outputs
// - modulation reference selects supply or ground
// - aux select picks reported monitor voltage
// - bias config write aborts running conversion
// - fresh conversion sequence after write completes
// - bias config kept in non-volatile storage
// - access needs valid maker password first
// - loop inversion selects inverted loop operation
// - gain bit selects quarter or full scale
// - bias reference selects supply or ground
// - feedback resistor field selects resistance
// - drive direction selects source or sink
// - shutdown polarity sets active level
// - first config non-volatile except soft reset and fault bits, writes restart conversions
`timescale 1ns/1ps
`include "lccr_map.vh"
module lccr_config_regs #(
  parameter DATA_W = 10,
  parameter CH_W = 3,
  parameter SOFT_RST_CYC = `LCCR_SOFT_RST_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // register access from the serial engine
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire maker_pw_valid,
  output reg [7:0] reg_rdata,
  output reg reg_rd_valid,
  // non-volatile storage
  input wire nvm_ready,
  input wire [7:0] nvm_out_cfg,
  input wire [7:0] nvm_bias_cfg,
  output reg nvm_wr_req,
  output reg [7:0] nvm_wr_addr,
  output reg [7:0] nvm_wr_data,
  input wire nvm_wr_ack,
  // status and mode inputs
  input wire diode_fault_det,
  input wire general_output_mode_select,
  input wire reset_mode_drive_low,
  input wire shutdown_req,
  // general output pin, open drain
  output reg general_output_pin_out,
  output reg general_output_pin_oe,
  // analog steering
  output reg shutdown_output,
  output reg out_drive_en,
  output reg modulation_reference_select,
  output reg [2:0] aux_voltage_select,
  output reg loop_inversion,
  output reg gain_quarter,
  output reg bias_reference_select,
  output reg [2:0] feedback_resistor_select,
  output reg drive_direction,
  // whole-device reset request
  output reg soft_reset_out,
  // converter handshake
  output wire adc_start,
  output wire adc_abort,
  output wire [CH_W-1:0] adc_ch,
  input wire adc_done,
  input wire [DATA_W-1:0] adc_data,
  // aux voltage result
  output reg [DATA_W-1:0] aux_voltage_result,
  output reg aux_result_valid
);
  localparam ST_LOAD = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_SOFT = 2'd2;
  localparam [15:0] SOFT_LAST = SOFT_RST_CYC - 1;

  // keep only the bits that live in non-volatile storage
  function [7:0] nv_bits;
    input [7:0] addr;
    input [7:0] d;
    begin
      if (addr == `LCCR_ADDR_OUT_CFG)
        nv_bits = d & `LCCR_OUT_CFG_NV_MASK;
      else
        nv_bits = d & `LCCR_BIAS_CFG_NV_MASK;
    end
  endfunction

  reg [1:0] state_r;
  reg [15:0] soft_cnt_r;
  reg [7:0] out_cfg_r;
  reg [7:0] bias_cfg_r;
  reg soft_pend_r;
  reg diode_flag_r;
  reg seq_abort_r;
  reg seq_restart_r;
  wire res_valid;
  wire [CH_W-1:0] res_ch;
  wire [DATA_W-1:0] res_data;
  wire acc_ok;
  wire wr_out;
  wire wr_bias;
  wire wr_hit;
  wire soft_req;
  reg [7:0] rd_mux;

  // nothing is reachable before the password or while reloading
  assign acc_ok = maker_pw_valid && (state_r == ST_RUN);
  assign wr_out = reg_wr && acc_ok && (reg_addr == `LCCR_ADDR_OUT_CFG);
  assign wr_bias = reg_wr && acc_ok && (reg_addr == `LCCR_ADDR_BIAS_CFG);
  assign wr_hit = wr_out || wr_bias;
  assign soft_req = wr_out && reg_wdata[`LCCR_B_SOFT_RST];

  // main state: reload storage, run, or hold the device in reset
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_LOAD;
      soft_cnt_r <= 16'h0000;
      soft_pend_r <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      case (state_r)
        ST_LOAD: begin
          // pending bit drops only once the reload is done
          if (nvm_ready && !nvm_wr_req) begin
            state_r <= ST_RUN;
            soft_pend_r <= 1'b0;
          end
        end
        ST_RUN: begin
          if (soft_req) begin
            state_r <= ST_SOFT;
            soft_pend_r <= 1'b1;
            soft_reset_out <= 1'b1;
            soft_cnt_r <= SOFT_LAST;
          end
        end
        ST_SOFT: begin
          if (soft_cnt_r == 16'h0000) begin
            state_r <= ST_LOAD;
            soft_reset_out <= 1'b0;
          end else begin
            soft_cnt_r <= soft_cnt_r - 16'h0001;
          end
        end
        default: state_r <= ST_LOAD;
      endcase
    end
  end

  // configuration storage; soft reset behaves like a power cycle
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_cfg_r <= `LCCR_OUT_CFG_RST;
      bias_cfg_r <= `LCCR_BIAS_CFG_RST;
    end else if (state_r == ST_SOFT) begin
      out_cfg_r <= `LCCR_OUT_CFG_RST;
      bias_cfg_r <= `LCCR_BIAS_CFG_RST;
    end else if (state_r == ST_LOAD) begin
      if (nvm_ready && !nvm_wr_req) begin
        out_cfg_r <= nv_bits(`LCCR_ADDR_OUT_CFG, nvm_out_cfg);
        bias_cfg_r <= nv_bits(`LCCR_ADDR_BIAS_CFG, nvm_bias_cfg);
      end
    end else begin
      // a soft reset write discards its other bits
      if (wr_out && !soft_req)
        out_cfg_r <= nv_bits(`LCCR_ADDR_OUT_CFG, reg_wdata);
      if (wr_bias)
        bias_cfg_r <= reg_wdata;
    end
  end

  // write-back to storage; a new write wins over the ack
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvm_wr_req <= 1'b0;
      nvm_wr_addr <= 8'h00;
      nvm_wr_data <= 8'h00;
    end else if ((wr_out && !soft_req) || wr_bias) begin
      nvm_wr_req <= 1'b1;
      nvm_wr_addr <= reg_addr;
      nvm_wr_data <= nv_bits(reg_addr, reg_wdata);
    end else if (nvm_wr_ack) begin
      nvm_wr_req <= 1'b0;
    end
  end

  // fault flag follows the detector and is never stored
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      diode_flag_r <= 1'b0;
    else if (state_r == ST_SOFT)
      diode_flag_r <= 1'b0;
    else
      diode_flag_r <= diode_fault_det;
  end

  // read data; refused or unmapped reads answer zero
  always @* begin
    rd_mux = 8'h00;
    if (acc_ok) begin
      if (reg_addr == `LCCR_ADDR_OUT_CFG) begin
        rd_mux = out_cfg_r;
        rd_mux[`LCCR_B_SOFT_RST] = soft_pend_r;
        rd_mux[`LCCR_B_DIODE_FLT] = diode_flag_r;
      end else if (reg_addr == `LCCR_ADDR_BIAS_CFG) begin
        rd_mux = bias_cfg_r;
      end
    end
  end

  // one-cycle read answer
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  // abort on the write cycle, restart once it has completed
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_abort_r <= 1'b0;
      seq_restart_r <= 1'b0;
    end else begin
      seq_abort_r <= wr_hit || (state_r == ST_SOFT);
      // also restart after a soft reset, once the device has left the reset hold
      seq_restart_r <= seq_abort_r && !wr_hit && (state_r != ST_SOFT);
    end
  end

  // pin and analog steering, all registered
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      general_output_pin_out <= 1'b0;
      general_output_pin_oe <= 1'b0;
      shutdown_output <= 1'b0;
      out_drive_en <= 1'b0;
      modulation_reference_select <= 1'b0;
      aux_voltage_select <= 3'h0;
      loop_inversion <= 1'b0;
      gain_quarter <= 1'b0;
      bias_reference_select <= 1'b0;
      feedback_resistor_select <= 3'h0;
      drive_direction <= 1'b1;
    end else begin
      // open drain: the pin is only ever pulled low
      general_output_pin_out <= 1'b0;
      if (general_output_mode_select)
        general_output_pin_oe <= reset_mode_drive_low;
      else
        general_output_pin_oe <= ~out_cfg_r[`LCCR_B_GPO_LVL];
      // polarity: asserted level is high only when the bit is one
      shutdown_output <= shutdown_req ~^ bias_cfg_r[`LCCR_B_SHUTDOWN_OUTPUT_POL];
      out_drive_en <= out_cfg_r[`LCCR_B_OUT_EN];
      modulation_reference_select <= out_cfg_r[`LCCR_B_MOD_REF];
      aux_voltage_select <= out_cfg_r[`LCCR_F_AUX_HI:`LCCR_F_AUX_LO];
      loop_inversion <= bias_cfg_r[`LCCR_B_LOOP_INV];
      gain_quarter <= bias_cfg_r[`LCCR_B_GAIN];
      // the block does not police the host keeps these opposite
      bias_reference_select <= bias_cfg_r[`LCCR_B_BIAS_REF];
      feedback_resistor_select <= bias_cfg_r[`LCCR_F_RFB_HI:`LCCR_F_RFB_LO];
      drive_direction <= bias_cfg_r[`LCCR_B_DRIVE_DIR];
    end
  end

  // conversion sequencer
  lccr_adc_seq #(
    .CH_W(CH_W),
    .NUM_CH(`LCCR_ADC_SLOTS),
    .DATA_W(DATA_W)
  ) u_seq (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .seq_abort(seq_abort_r),
    .seq_restart(seq_restart_r),
    .adc_start(adc_start),
    .adc_abort(adc_abort),
    .adc_ch(adc_ch),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .res_valid(res_valid),
    .res_ch(res_ch),
    .res_data(res_data)
  );

  // aux slot result lands in the aux voltage result
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_voltage_result <= {DATA_W{1'b0}};
      aux_result_valid <= 1'b0;
    end else begin
      aux_result_valid <= 1'b0;
      if (res_valid && (res_ch == `LCCR_AUX_SLOT)) begin
        aux_voltage_result <= res_data;
        aux_result_valid <= 1'b1;
      end
    end
  end
endmodule

// *** bench/lccr_config_regs_sva.sv ***
`timescale 1ns/1ps
module lccr_config_regs_sva (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // register access
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire maker_pw_valid,
  input wire [7:0] reg_rdata,
  input wire reg_rd_valid,
  // storage, status and outputs
  input wire nvm_ready,
  input wire nvm_wr_req,
  input wire diode_fault_det,
  input wire shutdown_req,
  input wire shutdown_output,
  input wire soft_reset_out,
  input wire adc_start,
  input wire adc_abort
);
  reg [1:0] run_cnt_r;
  wire run;
  wire wr_ok;
  // conservative settle count so that no write, shutdown or fault check is judged during the load phase
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      run_cnt_r <= 2'h0;
    else if (soft_reset_out)
      run_cnt_r <= 2'h0;
    else if (nvm_ready && !nvm_wr_req && run_cnt_r != 2'h3)
      run_cnt_r <= run_cnt_r + 2'h1;
  end
  assign run = run_cnt_r == 2'h3 && !soft_reset_out;
  assign wr_ok = run && reg_wr && maker_pw_valid;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_rd_answer:
    assert property (reg_rd |=> reg_rd_valid) else $error("read not answered");
  a_no_pw_read:
    assert property (reg_rd && !maker_pw_valid |=> reg_rdata == 8'h00)
      else $error("read without password gave data");
  a_soft_rst:
    assert property (wr_ok && reg_addr == 8'h00 && reg_wdata[7] |=> soft_reset_out)
      else $error("soft reset not started");
  a_bias_abort:
    assert property (wr_ok && reg_addr == 8'h01 |-> ##2 adc_abort)
      else $error("bias write did not abort conversion");
  a_seq_restart:
    assert property (wr_ok && reg_addr == 8'h01 |-> ##4 adc_start)
      else $error("conversion not restarted");
  a_soft_restart:
    assert property ($fell(soft_reset_out) |-> ##[1:4] adc_start)
      else $error("conversions not restarted after soft reset");
  a_cfg_abort:
    assert property (wr_ok && reg_addr == 8'h00 && !reg_wdata[7] |-> ##2 adc_abort)
      else $error("output config write did not abort");
  a_shutdown_output_follow:
    assert property (run && $changed(shutdown_req) && !reg_wr && !$past(reg_wr)
      && !$past(reg_wr, 2) |=> $changed(shutdown_output)) else $error("shutdown stuck");
  a_diode_flag:
    assert property (run && maker_pw_valid && reg_rd && reg_addr == 8'h00
      && diode_fault_det && $past(diode_fault_det) |=> reg_rdata[5])
      else $error("diode fault not reported");
endmodule
bind lccr_config_regs lccr_config_regs_sva chk_u (.ref_clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .maker_pw_valid, .reg_rdata, .reg_rd_valid, .nvm_ready,
  .nvm_wr_req, .diode_fault_det, .shutdown_req, .shutdown_output, .soft_reset_out,
  .adc_start, .adc_abort);

// *** bench/lccr_far_model.sv ***
`timescale 1ns/1ps
module lccr_far_model #(
  parameter [3:0] ADC_LAT = 4'h6
) (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // storage side
  output wire nvm_ready,
  output reg [7:0] nvm_out_cfg,
  output reg [7:0] nvm_bias_cfg,
  input wire nvm_wr_req,
  input wire [7:0] nvm_wr_addr,
  input wire [7:0] nvm_wr_data,
  output reg nvm_wr_ack,
  // converter side
  input wire adc_start,
  input wire adc_abort,
  input wire [2:0] adc_ch,
  output reg adc_done,
  output reg [9:0] adc_data
);
  reg busy_r;
  reg [3:0] cnt_r;
  reg [2:0] ch_r;
  // images are never touched by reset, only by acknowledged writes
  initial begin
    nvm_out_cfg = 8'h00;
    nvm_bias_cfg = 8'h02;
  end
  assign nvm_ready = 1'b1;
  always @(posedge ref_clk) begin
    if (nvm_wr_req && !nvm_wr_ack && nvm_wr_addr == 8'h00)
      nvm_out_cfg <= nvm_wr_data;
    if (nvm_wr_req && !nvm_wr_ack && nvm_wr_addr == 8'h01)
      nvm_bias_cfg <= nvm_wr_data;
  end
  // ack one cycle late, so the request must be held
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      nvm_wr_ack <= 1'b0;
    else
      nvm_wr_ack <= nvm_wr_req && !nvm_wr_ack;
  end
  // fixed latency converter; data toggles outside a result so stale values show
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      ch_r <= 3'h0;
      adc_done <= 1'b0;
      adc_data <= 10'h000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_abort)
        busy_r <= 1'b0;
      else if (adc_start) begin
        busy_r <= 1'b1;
        cnt_r <= ADC_LAT;
        ch_r <= adc_ch;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= {7'h40, ch_r};
      end else if (busy_r)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// *** bench/lccr_config_regs_tb.sv ***
`timescale 1ns/1ps
module lccr_config_regs_tb;
  // bias settings keep reference and drive direction opposite
  localparam [31:0] BIAS_SET = 32'ha1fd4a02;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg maker_pw_valid = 1'b0;
  reg diode_fault_det = 1'b0;
  reg general_output_mode_select = 1'b0;
  reg reset_mode_drive_low = 1'b0;
  reg shutdown_req = 1'b1;
  wire [7:0] reg_rdata, nvm_out_cfg, nvm_bias_cfg, nvm_wr_addr, nvm_wr_data;
  wire [2:0] aux_voltage_select, feedback_resistor_select, adc_ch;
  wire [9:0] adc_data;
  wire [9:0] aux_voltage_result;
  wire reg_rd_valid, nvm_ready, nvm_wr_req, nvm_wr_ack, general_output_pin_oe;
  wire shutdown_output, out_drive_en, modulation_reference_select, loop_inversion;
  wire gain_quarter, bias_reference_select, drive_direction, soft_reset_out;
  wire adc_start, adc_abort, adc_done;
  integer mismatches = 0;
  integer compares = 0;
  integer i;
  reg [7:0] v;
  always #10 ref_clk = ~ref_clk;
  lccr_config_regs #(.SOFT_RST_CYC(4)) dut_u (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .maker_pw_valid, .reg_rdata, .reg_rd_valid, .nvm_ready, .nvm_out_cfg,
    .nvm_bias_cfg, .nvm_wr_req, .nvm_wr_addr, .nvm_wr_data, .nvm_wr_ack, .diode_fault_det,
    .general_output_mode_select, .reset_mode_drive_low, .shutdown_req,
    .general_output_pin_out(), .general_output_pin_oe, .shutdown_output, .out_drive_en,
    .modulation_reference_select, .aux_voltage_select, .loop_inversion, .gain_quarter,
    .bias_reference_select, .feedback_resistor_select, .drive_direction, .soft_reset_out,
    .adc_start, .adc_abort, .adc_ch, .adc_done, .adc_data, .aux_voltage_result,
    .aux_result_valid());
  lccr_far_model far_u (.ref_clk, .reset_n, .nvm_ready, .nvm_out_cfg, .nvm_bias_cfg,
    .nvm_wr_req, .nvm_wr_addr, .nvm_wr_data, .nvm_wr_ack, .adc_start, .adc_abort, .adc_ch,
    .adc_done, .adc_data);
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // write strobe for one cycle, then let the fields settle
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk({7'h00, reg_rd_valid}, 8'h01);
      chk(reg_rdata, exp);
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(8'h01, 8'h00);
    wr(8'h01, 8'hfd);
    @(posedge ref_clk);
    maker_pw_valid <= 1'b1;
    rd(8'h01, 8'h02);
    rd(8'h05, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = BIAS_SET[i*8 +: 8];
      wr(8'h01, v);
      chk(loop_inversion, v[7]);
      chk(gain_quarter, v[6]);
      chk(bias_reference_select, v[5]);
      chk(feedback_resistor_select, v[4:2]);
      chk(drive_direction, v[1]);
      chk(shutdown_output, v[0]);
      shutdown_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(shutdown_output, !v[0]);
      shutdown_req <= 1'b1;
      rd(8'h01, v);
      chk(nvm_bias_cfg, v);
    end
    for (i = 0; i < 7; i = i + 1) begin
      v = {1'b0, !i[0], 1'b0, i[0], i[1], i[2:0]};
      wr(8'h00, v);
      chk(out_drive_en, v[4]);
      chk(modulation_reference_select, v[3]);
      chk(aux_voltage_select, i[2:0]);
      chk(general_output_pin_oe, !v[6]);
      rd(8'h00, v);
    end
    general_output_mode_select <= 1'b1;
    wr(8'h00, 8'h00);
    chk(general_output_pin_oe, 8'h00);
    general_output_mode_select <= 1'b0;
    diode_fault_det <= 1'b1;
    wr(8'h00, 8'h1a);
    rd(8'h00, 8'h3a);
    diode_fault_det <= 1'b0;
    rd(8'h00, 8'h1a);
    wr(8'h00, 8'h80);
    chk(soft_reset_out, 8'h01);
    for (i = 0; i < 100 && soft_reset_out; i = i + 1)
      @(posedge ref_clk);
    if (soft_reset_out) begin
      mismatches = mismatches + 1;
      end_sim;
    end
    repeat (4) @(posedge ref_clk);
    rd(8'h00, 8'h1a);
    rd(8'h01, BIAS_SET[31:24]);
    // the converter model returns 0x200 for slot zero
    repeat (30) @(posedge ref_clk);
    #1;
    chk(aux_voltage_result[9:2], 8'h80);
    end_sim;
  end
endmodule
